//--- core/adcrb_top.sv
// serial readout port, control word and result fifo of the converter
`timescale 1ns/1ns
// Functional notes
// [R1] reference level bit: 0 gives 2.5 V, 1 gives 1.25 V, needs enable bit
// [R2] without chip select, release output 10 ns or 100 ns after last edge; code waits one 100 ns core cycle for both settings
// [R3] continuous readout shifts data out without a preceding command byte
// [R4] host clocks exactly one result, only after data-ready goes low
// [R5] clock edges ignored while data-ready is high in continuous readout
// [R6] read still running four cycles before next result: abandon, data-ready high
// [R7] with checksum on, an abandoned read shows up as a checksum mismatch
// [R8] sixty-four ones or command 0x42 leave continuous readout, no checksum needed
// [R9] continuous readout suppressed while the result fifo is enabled
// [R10] coding bit: 0 straight binary, 1 offset binary with zero at 0x8000
// [R11] after reset reference, delay and continuous fields read zero

////////////////////////////////////////////////////////////////////////
// result buffer; depth must be a power of two
module adcrb_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 4
) (
  input  wire logic         i_core_clk,
  input  wire logic         i_reset_n,
  input  wire logic         i_clk_en,
  input  wire logic         i_in_valid,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_in_ready,
  output logic              o_out_valid,
  output logic [W-1:0]      o_out_data,
  input  wire logic         i_out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0]   count_r;
  logic [AW:0]   count_nxt;
  wire           push_w;
  wire           pop_w;

  // handshakes, frozen with the clock enable
  assign push_w      = i_clk_en & i_in_valid & o_in_ready;
  assign pop_w       = i_clk_en & o_out_valid & i_out_ready;
  assign o_out_valid = (count_r != '0);
  assign o_out_data  = mem[rd_ptr_r];
  assign count_nxt   = count_r + (AW+1)'(push_w) - (AW+1)'(pop_w);

  // storage has no reset, only valid slots are ever read
  always_ff @(posedge i_core_clk) begin
    if (push_w) begin
      mem[wr_ptr_r] <= i_in_data;
    end
  end

  // pointers wrap naturally at the power-of-two depth
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wr_ptr_r   <= '0;
      rd_ptr_r   <= '0;
      count_r    <= '0;
      o_in_ready <= 1'b1;
    end else begin
      wr_ptr_r   <= wr_ptr_r + AW'(push_w);
      rd_ptr_r   <= rd_ptr_r + AW'(pop_w);
      count_r    <= count_nxt;
      o_in_ready <= (count_nxt != (AW+1)'(DEPTH));
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////
module adcrb_top #(
  parameter int FIFO_DEPTH = 4
) (
  input  wire logic                    i_core_clk,
  input  wire logic                    i_reset_n,
  input  wire logic                    i_clk_en,
  input  wire adcrb_pkg::adcrb_spi_in_t i_spi,
  output logic                         o_sdo,
  output logic                         o_sdo_oe,
  output logic                         o_rdy_n,
  input  wire logic                    i_sample_valid,
  input  wire adcrb_pkg::adcrb_sample_t i_sample,
  output logic                         o_sample_ready,
  input  wire logic                    i_conv_warn,
  input  wire logic                    i_fifo_en,
  input  wire logic                    i_crc_en,
  output logic [15:0]                  o_ctrl_word,
  output logic                         o_ref_en,
  output logic                         o_ref_1v25
);
  import adcrb_pkg::*;

  adcrb_state_t  state_r;
  logic [4:0]    bitcnt_r;
  logic [15:0]   ctrl_r;
  logic [15:0]   sh_in_r;
  logic [23:0]   sh_out_r;
  logic [15:0]   res_r;
  logic [6:0]    ones_r;
  logic [4:0]    frame_bits_r;
  logic [3:0]    rel_r;
  logic          sclk_q_r;
  logic          reading_r;
  adcrb_sample_t fifo_q_w;
  logic [15:0]   fifo_data_w;
  logic          fifo_valid_w;

  function automatic logic [7:0] crc8(input logic [15:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 15; i >= 0; i--) begin
      c = (c[7] ^ d[i]) ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
    end
    return c;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // serial edge decode; inputs arrive synchronous to the core clock
  wire        sel_w   = ~ctrl_r[BIT_CS_USE] | ~i_spi.cs_n;
  wire        rise_w  = i_clk_en & sel_w & i_spi.sclk & ~sclk_q_r;
  wire        fall_w  = i_clk_en & sel_w & ~i_spi.sclk & sclk_q_r;
  wire        desel_w = i_clk_en & ~sel_w;
  wire        cont_w  = ctrl_r[BIT_CONT] & ~i_fifo_en; // [R9]
  wire [7:0]  cmd_w   = {sh_in_r[6:0], i_spi.sdi};
  wire [15:0] word_w  = {sh_in_r[14:0], i_spi.sdi};

  // command and frame decode
  wire in_cmd_w   = (state_r == ST_CMD);
  wire cmd_done_w = rise_w & in_cmd_w & (bitcnt_r == CMD_BITS - 5'h01);
  wire is_rd_w    = cmd_w[CMD_RD_BIT];
  wire go_wr_w    = cmd_done_w & ~is_rd_w & (cmd_w[5:0] == ADDR_CTRL);
  wire go_rdc_w   = cmd_done_w & is_rd_w & (cmd_w[5:0] == ADDR_CTRL);
  // the exit byte is taken bare even with checksums on
  wire go_rdd_w   = cmd_done_w & (cmd_w == CMD_READ_DATA); // [R8]
  // no command byte needed, and no start while data-ready is high
  wire start_c_w  = fall_w & in_cmd_w & (bitcnt_r == '0) & cont_w & ~o_rdy_n; // [R3] [R5]
  wire take_w     = go_rdd_w | start_c_w;
  wire wr_done_w  = rise_w & (state_r == ST_WR) & (bitcnt_r == FRAME_PLAIN - 5'h01);
  wire rd_done_w  = rise_w & (state_r == ST_RD) & (bitcnt_r == frame_bits_r - 5'h01);
  wire abandon_w  = i_clk_en & i_conv_warn & reading_r & cont_w; // [R6]
  wire swrst_w    = rise_w & i_spi.sdi & (ones_r == SWRST_ONES - 7'h01); // [R8]
  wire drain_w    = ~reading_r & ~take_w;
  wire pop_w      = i_clk_en & fifo_valid_w & drain_w;

  // frame contents; checksum trails the word so a cut frame fails it
  wire [15:0] rd_word_w  = go_rdc_w ? (ctrl_r & CTRL_MASK) : res_r;
  wire [23:0] load_w     = {rd_word_w, crc8(rd_word_w)}; // [R7]
  wire [4:0]  frame_n_w  = i_crc_en ? FRAME_CRC : FRAME_PLAIN;
  wire [3:0]  rel_cyc_w  = ctrl_r[BIT_REL_DEL] ? REL_LONG_CYC : REL_SHORT_CYC; // [R2]
  wire        rel_go_w   = (rd_done_w & ~ctrl_r[BIT_CS_USE]) | abandon_w;

  // output coding of the signed converter result
  wire [15:0] raw_w   = fifo_q_w.code;
  wire [15:0] offs_w  = {~raw_w[15], raw_w[14:0]};
  wire [15:0] strt_w  = raw_w[15] ? 16'h0000 : {raw_w[14:0], raw_w[14]};
  wire [15:0] coded_w = ctrl_r[BIT_CODING] ? offs_w : strt_w; // [R10]

  assign fifo_q_w = fifo_data_w;

  ////////////////////////////////////////////////////////////////////
  adcrb_fifo #(
    .W     ($bits(adcrb_sample_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_core_clk  (i_core_clk),
    .i_reset_n   (i_reset_n),
    .i_clk_en    (i_clk_en),
    .i_in_valid  (i_sample_valid),
    .i_in_data   (i_sample),
    .o_in_ready  (o_sample_ready),
    .o_out_valid (fifo_valid_w),
    .o_out_data  (fifo_data_w),
    .i_out_ready (drain_w)
  );

  ////////////////////////////////////////////////////////////////////
  // sclk history, sdi shifter and run of ones
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sclk_q_r <= 1'b1;
      sh_in_r  <= '0;
      ones_r   <= '0;
    end else if (i_clk_en) begin
      sclk_q_r <= i_spi.sclk;
      if (rise_w) begin
        sh_in_r <= word_w;
        ones_r  <= (i_spi.sdi && !swrst_w) ? ones_r + 7'h01 : 7'h00;
      end
    end
  end

  // frame state and bit count
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_r  <= ST_CMD;
      bitcnt_r <= '0;
    end else if (desel_w | swrst_w | abandon_w | rd_done_w | wr_done_w) begin
      state_r  <= ST_CMD; // [R6]
      bitcnt_r <= '0;
    end else if (go_wr_w) begin
      state_r  <= ST_WR;
      bitcnt_r <= '0;
    end else if (go_rdc_w | take_w) begin
      state_r  <= ST_RD; // [R3]
      bitcnt_r <= '0;
    end else if (cmd_done_w) begin
      bitcnt_r <= '0;
    end else if (rise_w) begin
      bitcnt_r <= bitcnt_r + 5'h01;
    end
  end

  // control word; reset returns it to its power-up value
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ctrl_r <= CTRL_RST; // [R11]
    end else if (swrst_w) begin
      ctrl_r <= CTRL_RST; // [R8]
    end else if (wr_done_w) begin
      ctrl_r <= word_w & CTRL_MASK;
    end else if (go_rdd_w) begin
      ctrl_r[BIT_CONT] <= 1'b0; // [R8]
    end
  end

  // registered copies of the control outputs
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_ctrl_word <= CTRL_RST;
      o_ref_en    <= 1'b0;
      o_ref_1v25  <= 1'b0;
    end else if (i_clk_en) begin
      o_ctrl_word <= ctrl_r;
      o_ref_en    <= ctrl_r[BIT_REF_EN];
      o_ref_1v25  <= ctrl_r[BIT_REF_EN] & ctrl_r[BIT_REF_LVL]; // [R1]
    end
  end

  // result and data-ready; a new result wins over a finished read
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      res_r     <= '0;
      o_rdy_n   <= 1'b1;
      reading_r <= 1'b0;
    end else begin
      if (pop_w) begin
        res_r   <= coded_w;
        o_rdy_n <= 1'b0;
      end else if ((rd_done_w & reading_r) | abandon_w) begin
        o_rdy_n <= 1'b1; // [R5] [R6]
      end
      if (take_w) begin
        reading_r <= 1'b1;
      end else if (rd_done_w | abandon_w | desel_w | swrst_w) begin
        reading_r <= 1'b0;
      end
    end
  end

  // output shifter, enable and release timer
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_sdo        <= 1'b0;
      o_sdo_oe     <= 1'b0;
      sh_out_r     <= '0;
      frame_bits_r <= FRAME_PLAIN;
      rel_r        <= '0;
    end else if (i_clk_en) begin
      if (abandon_w) begin
        o_sdo    <= 1'b1; // [R7]
        sh_out_r <= '1;
      end else if (start_c_w) begin
        o_sdo    <= load_w[23];
        sh_out_r <= {load_w[22:0], 1'b0};
      end else if (go_rdc_w | go_rdd_w) begin
        sh_out_r <= load_w;
      end else if (fall_w && state_r == ST_RD) begin
        o_sdo    <= sh_out_r[23];
        sh_out_r <= {sh_out_r[22:0], 1'b0};
      end
      if (start_c_w | go_rdc_w | go_rdd_w) begin
        frame_bits_r <= frame_n_w; // [R7]
      end
      if (desel_w) begin
        o_sdo_oe <= 1'b0;
        rel_r    <= '0;
      end else if (start_c_w || (fall_w && state_r == ST_RD)) begin
        o_sdo_oe <= 1'b1;
        rel_r    <= '0;
      end else if (rel_go_w) begin
        rel_r <= rel_cyc_w; // [R2]
      end else if (rel_r != '0) begin
        rel_r <= rel_r - 4'h1;
        if (rel_r == 4'h1) begin
          o_sdo_oe <= 1'b0; // [R2]
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks
  AST_REF_LEVEL: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // [R1]
    i_clk_en && !ctrl_r[BIT_REF_EN] |=> !o_ref_1v25)
    else $error("1.25 V reference selected without the enable bit");

  AST_RELEASE: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // [R2]
    rd_done_w && !ctrl_r[BIT_CS_USE] && !ctrl_r[BIT_REL_DEL] ##1 (i_clk_en && !fall_w && !desel_w)
    |=> !o_sdo_oe)
    else $error("output not released after the short delay");

  AST_CONT_START: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // [R3]
    start_c_w |=> state_r == ST_RD && reading_r && o_sdo_oe)
    else $error("continuous readout did not start on the first edge");

  AST_IGNORE_HIGH: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // [R5]
    fall_w && in_cmd_w && o_rdy_n && !cmd_done_w |=> !reading_r)
    else $error("readout started while data-ready was high");

  AST_ABANDON: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // [R6]
    abandon_w |=> o_rdy_n && state_r == ST_CMD && !reading_r)
    else $error("late read was not abandoned");

  AST_CRC_FRAME: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // [R7]
    (start_c_w || go_rdd_w) && i_crc_en |=> frame_bits_r == FRAME_CRC)
    else $error("checksum byte missing from the readout frame");

  AST_SW_RESET: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // [R8]
    swrst_w |=> ctrl_r == CTRL_RST && state_r == ST_CMD)
    else $error("run of ones did not reset the control word");

  AST_EXIT_CMD: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // [R8]
    go_rdd_w && !swrst_w |=> !ctrl_r[BIT_CONT])
    else $error("read data command did not leave continuous readout");

  AST_FIFO_BLOCK: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // [R9]
    i_fifo_en |-> !start_c_w)
    else $error("continuous readout ran with the fifo enabled");

  AST_OFFSET_ZERO: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // [R10]
    pop_w && ctrl_r[BIT_CODING] && raw_w == 16'h0000 |=> res_r == CODE_MID)
    else $error("offset binary zero is not mid scale");

  AST_RESET_VAL: assert property (@(posedge i_core_clk) // [R11]
    $rose(i_reset_n) |-> ctrl_r[BIT_REF_LVL] == 1'b0 && !ctrl_r[BIT_REL_DEL] && !ctrl_r[BIT_CONT])
    else $error("control fields not zero after reset");
endmodule

//--- shared/adcrb_pkg.sv
// constants and types for the converter control word and readout port
package adcrb_pkg;
  localparam int DATA_W = 16;
  localparam int CRC_W  = 8;
  // control word field positions
  localparam int BIT_CODING  = 14;
  localparam int BIT_REF_LVL = 13;
  localparam int BIT_REL_DEL = 12;
  localparam int BIT_CONT    = 11;
  localparam int BIT_CS_USE  = 9;
  localparam int BIT_REF_EN  = 8;
  localparam logic [15:0] CTRL_RST  = 16'h4000;
  localparam logic [15:0] CTRL_MASK = 16'h7B00;
  // command byte layout and serial frame lengths
  localparam logic [7:0] CMD_READ_DATA = 8'h42;
  localparam int         CMD_RD_BIT    = 6;
  localparam logic [5:0] ADDR_CTRL     = 6'h01;
  localparam logic [5:0] ADDR_DATA     = 6'h02;
  localparam logic [6:0] SWRST_ONES    = 7'h40;
  localparam logic [4:0] CMD_BITS      = 5'h08;
  localparam logic [4:0] FRAME_PLAIN   = 5'h10;
  localparam logic [4:0] FRAME_CRC     = 5'h18;
  localparam logic [7:0] CRC_POLY      = 8'h07;
  localparam logic [15:0] CODE_MID     = 16'h8000;
  // output release delay, rounded up to whole core cycles
  localparam int CLK_PERIOD_NS = 100;
  localparam int REL_SHORT_NS  = 10;
  localparam int REL_LONG_NS   = 100;
  localparam int REL_SHORT_RAW = (REL_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REL_LONG_RAW  = (REL_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] REL_SHORT_CYC = 4'(REL_SHORT_RAW < 1 ? 1 : REL_SHORT_RAW);
  localparam logic [3:0] REL_LONG_CYC  = 4'(REL_LONG_RAW < 1 ? 1 : REL_LONG_RAW);

  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic sdi;
  } adcrb_spi_in_t;

  typedef struct packed {
    logic [15:0] code;
  } adcrb_sample_t;

  typedef enum logic [1:0] {
    ST_CMD = 2'b00,
    ST_WR  = 2'b01,
    ST_RD  = 2'b10
  } adcrb_state_t;
endpackage

//--- sim/adcrb_host_model.sv
// host side serial master model for the converter readout port
`timescale 1ns/1ns
module adcrb_host_model
  import adcrb_pkg::*;
(
  input  wire logic               i_core_clk,
  input  wire logic               i_sdo,
  input  wire logic               i_sdo_oe,
  output adcrb_pkg::adcrb_spi_in_t o_spi,
  output logic                    o_oe_after,
  output logic                    o_oe_seen
);
  // phase length covers the one-register sclk edge detect with margin
  localparam int HALF = 4;
  logic drv_last_r;

  // sclk idles high, chip select idles high
  initial begin
    o_spi      = '{sclk: 1'b1, cs_n: 1'b1, sdi: 1'b1};
    o_oe_after = 1'b0;
    o_oe_seen  = 1'b0;
    drv_last_r = 1'b0;
  end

  // no pull on the data line: once released it shows the inverse of its last driven level
  always @(posedge i_core_clk) begin
    if (i_sdo_oe) begin
      drv_last_r <= i_sdo;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // one frame of n bits msb first; it starts at once without checking data-ready
  task automatic xfer(input logic [63:0] tx, input int n, output logic [63:0] rx);
    rx         = '0;
    o_oe_seen  = 1'b0;
    o_spi.cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      repeat (HALF) @(negedge i_core_clk);
      o_spi.sclk = 1'b0;
      o_spi.sdi  = tx[i];
      repeat (HALF) @(negedge i_core_clk);
      rx[i]      = i_sdo_oe ? i_sdo : ~drv_last_r;
      o_oe_seen  = o_oe_seen | i_sdo_oe;
      o_spi.sclk = 1'b1;
    end
    // release is judged while select is still low
    repeat (5) @(negedge i_core_clk);
    o_oe_after = i_sdo_oe;
    o_spi.sdi  = ~o_spi.sdi;
    o_spi.cs_n = 1'b1;
    @(negedge i_core_clk);
  endtask
endmodule

//--- sim/testbench.sv
// self-checking bench for the converter readout port
`timescale 1ns/1ns
module testbench;
  import adcrb_pkg::*;
  logic          i_core_clk = 1'b0;
  logic          i_reset_n = 1'b0;
  logic          i_sample_valid = 1'b0;
  logic          i_conv_warn = 1'b0;
  logic          i_fifo_en = 1'b0;
  logic          i_crc_en = 1'b0;
  adcrb_sample_t i_sample = '0;
  adcrb_spi_in_t spi;
  logic          o_sdo, o_sdo_oe, o_rdy_n, o_sample_ready, o_ref_1v25, o_ref_en, oe_after, oe_seen;
  logic [15:0]   o_ctrl_word;
  logic [63:0]   rx;
  int            miscompares = 0;
  int            total_checks = 0;

  // 10 MHz core clock
  always #50 i_core_clk = ~i_core_clk;

  adcrb_top #(.FIFO_DEPTH(4)) u_dut (
    .i_core_clk    (i_core_clk),
    .i_reset_n     (i_reset_n),
    .i_clk_en      (1'b1),
    .i_spi         (spi),
    .o_sdo         (o_sdo),
    .o_sdo_oe      (o_sdo_oe),
    .o_rdy_n       (o_rdy_n),
    .i_sample_valid(i_sample_valid),
    .i_sample      (i_sample),
    .o_sample_ready(o_sample_ready),
    .i_conv_warn   (i_conv_warn),
    .i_fifo_en     (i_fifo_en),
    .i_crc_en      (i_crc_en),
    .o_ctrl_word   (o_ctrl_word),
    .o_ref_en      (o_ref_en),
    .o_ref_1v25    (o_ref_1v25)
  );

  adcrb_host_model u_host (
    .i_core_clk(i_core_clk),
    .i_sdo     (o_sdo),
    .i_sdo_oe  (o_sdo_oe),
    .o_spi     (spi),
    .o_oe_after(oe_after),
    .o_oe_seen (oe_seen)
  );

  ////////////////////////////////////////////////////////////////////////
  // shared helpers
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // bench's own checksum, polynomial 0x07, zero start
  function automatic logic [7:0] crc8(input logic [15:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 15; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    end
    return c;
  endfunction

  task automatic wr_ctrl(input logic [15:0] w);
    u_host.xfer({40'h0, 8'h01, w}, 24, rx);
    repeat (3) @(negedge i_core_clk);
  endtask

  task automatic rd_ctrl(input logic [15:0] exp);
    u_host.xfer({40'h0, 8'h41, 16'h0}, 24, rx);
    check("ctrl readback", rx[15:0], exp);
  endtask

  task automatic rd_data(input int n);
    u_host.xfer({40'h0, 8'h42, 16'h0} << (n - 24), n, rx);
  endtask

  // valid held until ready was high at the taking edge
  task automatic push(input logic [15:0] v);
    i_sample_valid = 1'b1;
    i_sample.code  = v;
    for (int i = 0; i < 50 && o_sample_ready !== 1'b1; i++) @(negedge i_core_clk);
    @(negedge i_core_clk);
    i_sample_valid = 1'b0;
    // let an edge pass so a following push does not re-raise valid in the same step
    @(negedge i_core_clk);
  endtask

  task automatic wait_rdy();
    for (int i = 0; i < 100 && o_rdy_n !== 1'b0; i++) @(negedge i_core_clk);
    check("result ready", o_rdy_n, 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    check("ctrl after reset", o_ctrl_word, 16'h4000);
    check("level after reset", o_ref_1v25, 1'b0);
    rd_ctrl(16'h4000);
  endtask

  task automatic t_ref();
    logic [15:0] w [4] = '{16'h2100, 16'h0100, 16'h2000, 16'hF7FF};
    logic [15:0] r [4] = '{16'h2100, 16'h0100, 16'h2000, 16'h7300};
    logic        l [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
    foreach (w[i]) begin
      wr_ctrl(w[i]);
      check("reference 1v25", o_ref_1v25, l[i]);
      check("reference enable", o_ref_en, r[i][8]);
      rd_ctrl(r[i]);
    end
  endtask

  task automatic t_coding();
    logic [15:0] cw [4] = '{16'h4200, 16'h4200, 16'h0200, 16'h0200};
    logic [15:0] sv [4] = '{16'h0000, 16'h7FFF, 16'hFFFB, 16'h1234};
    logic [15:0] ex [4] = '{16'h8000, 16'hFFFF, 16'h0000, 16'h2468};
    foreach (cw[i]) begin
      wr_ctrl(cw[i]);
      push(sv[i]);
      wait_rdy();
      rd_data(24);
      check("coded result", rx[15:0], ex[i]);
    end
  endtask

  // fill the buffer while a read holds off popping, then drain it
  task automatic t_fifo();
    fork
      rd_data(24);
      begin
        repeat (90) @(negedge i_core_clk);
        for (int k = 1; k <= 4; k++) push(16'(k));
        @(negedge i_core_clk);
        check("buffer full", o_sample_ready, 1'b0);
      end
    join
    repeat (10) @(negedge i_core_clk);
    check("buffer drained", o_sample_ready, 1'b1);
    rd_data(24);
    check("newest word kept", rx[15:0], 16'h0008);
  endtask

  task automatic t_cont();
    for (int d = 0; d < 2; d++) begin
      wr_ctrl(16'h4800 | (16'(d) << 12));
      push(16'h0055);
      wait_rdy();
      u_host.xfer(64'h0, 16, rx);
      check("no-command read", rx[15:0], 16'h8055);
      check("released after edge", oe_after, 1'b0);
      check("ready after read", o_rdy_n, 1'b1);
      u_host.xfer(64'h0, 16, rx);
      check("ignored clocks", oe_seen, 1'b0);
      push(16'h0001);
      wait_rdy();
      u_host.xfer(64'h0, 16, rx);
      check("second result", rx[15:0], 16'h8001);
      // exit byte only while data-ready is high, else its clocks start a readout
      rd_data(24);
      rd_ctrl(16'h4000 | (16'(d) << 12));
    end
  endtask

  task automatic t_crc();
    // chip select in use so deselect realigns the bit count after the cut frame
    wr_ctrl(16'h4A00);
    i_crc_en = 1'b1;
    push(16'h0055);
    wait_rdy();
    u_host.xfer(64'h0, 24, rx);
    check("crc read data", rx[23:8], 16'h8055);
    check("crc good", rx[7:0], crc8(16'h8055));
    push(16'h0066);
    wait_rdy();
    fork
      u_host.xfer(64'h0, 24, rx);
      begin
        repeat (40) @(negedge i_core_clk);
        i_conv_warn = 1'b1;
        @(negedge i_core_clk);
        i_conv_warn = 1'b0;
        @(negedge i_core_clk);
        check("abandon ready", o_rdy_n, 1'b1);
      end
    join
    check("abandon tail released", rx[7:0], 8'h00);
    check("abandon crc fails", crc8(rx[23:8]) !== rx[7:0], 1'b1);
    push(16'h0077);
    wait_rdy();
    u_host.xfer(64'h0, 24, rx);
    check("crc read data 2", rx[23:8], 16'h8077);
    check("crc good 2", rx[7:0], crc8(16'h8077));
    rd_data(32);
    i_crc_en = 1'b0;
    rd_ctrl(16'h4200);
  endtask

  // buffer enabled blocks continuous reads; software reset restores defaults
  task automatic t_fifo_en();
    i_fifo_en = 1'b1;
    wr_ctrl(16'h6B00);
    check("reference 1v25 set", o_ref_1v25, 1'b1);
    push(16'h0011);
    repeat (5) @(negedge i_core_clk);
    u_host.xfer(64'h0, 16, rx);
    check("no continuous read", oe_seen, 1'b0);
    u_host.xfer({64{1'b1}}, 64, rx);
    repeat (3) @(negedge i_core_clk);
    check("level after soft reset", o_ref_1v25, 1'b0);
    i_fifo_en = 1'b0;
    rd_ctrl(16'h4000);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (16) @(negedge i_core_clk);
    i_reset_n = 1'b1;
    @(negedge i_core_clk);
    t_reset();
    t_ref();
    t_coding();
    t_fifo();
    t_cont();
    t_crc();
    t_fifo_en();
    conclude();
  end

  // watchdog, run needs about 8k cycles
  initial begin
    #(100 * 60000);
    miscompares++;
    conclude();
  end
endmodule
